// File: verilog/ext_bus_strobes.sv
// External memory bus strobes, reset pin and fetch select handling
//
// Operation
// - Reset pin high two machine cycles with clock running resets device.
// - Watchdog reset drives the reset pin high as an output.
// - Address latch strobe pulses during every external memory access.
// - Latch strobe rate is oscillator/6, or oscillator/3 in double speed.
// - One latch strobe pulse is skipped in each external data access.
// - Latch strobe disable bit silences the strobe on internal fetches.
// - During flash programming the latch strobe pin is the program pulse input.
// - External code fetch activates program store strobe twice per machine cycle.
// - Two program store strobes are skipped in each external data access.
// - Program store strobe never active on internal program fetches.
// - With security level 1, fetch select is latched at reset.
// - Separate read and write strobes for external data memory.
module ext_bus_strobes (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic double_speed_mode,
  input  wire logic latch_strobe_disable_bit,
  input  wire logic security_level1,
  input  wire logic flash_programming,
  input  wire logic fetch_in_internal_range,
  input  wire logic xdata_access,
  input  wire logic xdata_write,
  input  wire logic watchdog_reset,
  input  wire logic external_fetch_select,
  input  wire logic rst_pin_in,
  output logic      rst_pin_out,
  output logic      rst_pin_oe,
  input  wire logic ale_pin_in,
  output logic      ale_pin_out,
  output logic      ale_pin_oe,
  output logic      program_pulse_input,
  output logic      program_store_strobe_n,
  output logic      xdata_read_strobe_n,
  output logic      xdata_write_strobe_n,
  output logic      system_reset,
  output logic      machine_cycle_start
);

  ext_bus_pkg::mc_state_t state;
  ext_bus_pkg::mc_state_t next_state;
  logic       phase;
  logic       state_tick;
  logic       cycle_end;
  logic [4:0] rst_cnt;
  logic [4:0] rst_thr;
  logic       pin_reset;
  logic [6:0] wdt_cnt;
  logic       fetch_sel_latched;
  logic       fetch_sel_eff;
  logic       ext_fetch_now;
  logic       ext_fetch_cycle;
  logic       data_cycle;
  logic       data_write;
  logic       ale_allow;
  logic       next_ale;
  logic       next_store_active;

  // Reset pin qualification counted in oscillator clocks
  assign rst_thr = double_speed_mode ? ext_bus_pkg::RESET_HOLD_CLK_DS
                                     : ext_bus_pkg::RESET_HOLD_CLK_STD;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_cnt <= '0;
    else if (!rst_pin_in)
      rst_cnt <= '0;
    else if (rst_cnt < rst_thr)
      rst_cnt <= rst_cnt + 5'h01;
  end

  assign pin_reset = rst_pin_in && (rst_cnt >= rst_thr);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wdt_cnt <= '0;
    else if (watchdog_reset)
      wdt_cnt <= ext_bus_pkg::WDT_DRIVE_CLKS;
    else if (wdt_cnt != 7'h00)
      wdt_cnt <= wdt_cnt - 7'h01;
  end

  assign rst_pin_oe  = (wdt_cnt != 7'h00);
  assign rst_pin_out = rst_pin_oe;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      system_reset <= 1'b1;
    else
      system_reset <= pin_reset || watchdog_reset || (wdt_cnt != 7'h00);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fetch_sel_latched <= ext_bus_pkg::SELECT_LATCH_RESET;
    else if (system_reset)
      fetch_sel_latched <= external_fetch_select;
  end

  assign fetch_sel_eff = security_level1 ? fetch_sel_latched : external_fetch_select;
  assign ext_fetch_now = !fetch_sel_eff || !fetch_in_internal_range;

  // Two clocks per state normally, one in double speed mode
  assign state_tick          = double_speed_mode || phase;
  assign cycle_end           = state_tick && (state == ext_bus_pkg::ST_S6);
  assign machine_cycle_start = cycle_end && !system_reset;

  always_comb
  begin
    case (state)
      ext_bus_pkg::ST_S1: next_state = ext_bus_pkg::ST_S2;
      ext_bus_pkg::ST_S2: next_state = ext_bus_pkg::ST_S3;
      ext_bus_pkg::ST_S3: next_state = ext_bus_pkg::ST_S4;
      ext_bus_pkg::ST_S4: next_state = ext_bus_pkg::ST_S5;
      ext_bus_pkg::ST_S5: next_state = ext_bus_pkg::ST_S6;
      default:            next_state = ext_bus_pkg::ST_S1;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ext_bus_pkg::ST_S1;
      phase <= 1'b0;
    end
    else if (system_reset)
    begin
      state <= ext_bus_pkg::ST_S1;
      phase <= 1'b0;
    end
    else
    begin
      phase <= double_speed_mode ? 1'b0 : !phase;
      if (state_tick)
        state <= next_state;
    end
  end

  // Access kind is fixed for a whole machine cycle to keep strobes glitch free
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ext_fetch_cycle <= 1'b0;
      data_cycle      <= 1'b0;
      data_write      <= 1'b0;
    end
    else if (system_reset)
    begin
      ext_fetch_cycle <= 1'b0;
      data_cycle      <= 1'b0;
      data_write      <= 1'b0;
    end
    else if (cycle_end)
    begin
      ext_fetch_cycle <= ext_fetch_now;
      data_cycle      <= xdata_access;
      data_write      <= xdata_write;
    end
  end

  assign ale_allow = !latch_strobe_disable_bit || ext_fetch_cycle || data_cycle;

  // latch strobe at S1 and S4
  // S1 pulse dropped in data cycle
  always_comb
  begin
    next_ale = 1'b0;
    if (state == ext_bus_pkg::ST_S1)
      next_ale = ale_allow && !data_cycle;
    else if (state == ext_bus_pkg::ST_S4)
      next_ale = ale_allow;
  end

  // program store strobe twice per cycle
  assign next_store_active = ext_fetch_cycle && !data_cycle &&
                             (state != ext_bus_pkg::ST_S1) && (state != ext_bus_pkg::ST_S4);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ale_pin_out            <= 1'b0;
      program_store_strobe_n <= ext_bus_pkg::STROBE_N_IDLE;
      xdata_read_strobe_n    <= ext_bus_pkg::STROBE_N_IDLE;
      xdata_write_strobe_n   <= ext_bus_pkg::STROBE_N_IDLE;
    end
    else if (system_reset)
    begin
      ale_pin_out            <= 1'b0;
      program_store_strobe_n <= ext_bus_pkg::STROBE_N_IDLE;
      xdata_read_strobe_n    <= ext_bus_pkg::STROBE_N_IDLE;
      xdata_write_strobe_n   <= ext_bus_pkg::STROBE_N_IDLE;
    end
    else
    begin
      ale_pin_out            <= next_ale && !flash_programming;
      program_store_strobe_n <= !next_store_active;
      // data read and write strobes, S2 to S5
      xdata_read_strobe_n    <= !(data_cycle && !data_write &&
                                  (state >= ext_bus_pkg::ST_S2) && (state <= ext_bus_pkg::ST_S5));
      xdata_write_strobe_n   <= !(data_cycle && data_write &&
                                  (state >= ext_bus_pkg::ST_S2) && (state <= ext_bus_pkg::ST_S5));
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ale_pin_oe          <= 1'b0;
      program_pulse_input <= 1'b0;
    end
    else
    begin
      ale_pin_oe          <= !flash_programming;
      program_pulse_input <= flash_programming && ale_pin_in;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_ale_one_state;
    ##1 ale_pin_out [*2] ##1 !ale_pin_out;
  endsequence

  sequence s_store_fast_cycle;
    ##1 program_store_strobe_n ##1 !program_store_strobe_n [*2]
    ##1 program_store_strobe_n ##1 !program_store_strobe_n [*2];
  endsequence

  AST_RESET_PIN_HOLD: assert property (
    pin_reset |=> system_reset)
    else $error("Reset pin held long enough did not reset");
  AST_WDT_DRIVES_PIN: assert property (
    watchdog_reset |=> (rst_pin_oe && rst_pin_out) [*8])
    else $error("Watchdog reset did not drive the reset pin");
  AST_ALE_STD_RATE: assert property (
    (state == ext_bus_pkg::ST_S3) && state_tick && !system_reset && !double_speed_mode &&
    !flash_programming && !latch_strobe_disable_bit && !pin_reset && !watchdog_reset
    |=> s_ale_one_state)
    else $error("Latch strobe not two clocks wide at S4");
  AST_ALE_DATA_SKIP: assert property (
    cycle_end && !system_reset && xdata_access |=> ##1 !ale_pin_out)
    else $error("Latch strobe not skipped in data cycle");
  AST_ALE_QUIET: assert property (
    latch_strobe_disable_bit && !ext_fetch_cycle && !data_cycle |=> !ale_pin_out)
    else $error("Latch strobe active on internal fetch while disabled");
  AST_ALE_EXT_ACCESS: assert property (
    (state == ext_bus_pkg::ST_S4) && data_cycle && !system_reset && !flash_programming &&
    !pin_reset && !watchdog_reset |=> ale_pin_out)
    else $error("Latch strobe missing on external data access");
  AST_ALE_PROGRAM_PULSE_INPUT_INPUT: assert property (
    flash_programming |=> !ale_pin_oe && (program_pulse_input == $past(ale_pin_in)))
    else $error("Latch strobe pin not an input while programming");
  AST_STORE_TWICE: assert property (
    cycle_end && !system_reset && double_speed_mode && ext_fetch_now && !xdata_access &&
    !pin_reset && !watchdog_reset && !rst_pin_in
    |=> s_store_fast_cycle)
    else $error("Program store strobe not twice per machine cycle");
  AST_STORE_DATA_SKIP: assert property (
    data_cycle |=> program_store_strobe_n)
    else $error("Program store strobe active in data cycle");
  AST_STORE_INTERNAL: assert property (
    !ext_fetch_cycle |=> program_store_strobe_n)
    else $error("Program store strobe active on internal fetch");
  AST_SELECT_HELD: assert property (
    security_level1 && !system_reset |=> $stable(fetch_sel_latched))
    else $error("Latched fetch select changed outside reset");
  AST_RD_STROBE: assert property (
    (state == ext_bus_pkg::ST_S3) && data_cycle && !data_write && !system_reset
    |=> !xdata_read_strobe_n && xdata_write_strobe_n)
    else $error("Read strobe wrong during data read");

endmodule // ext_bus_strobes

// File: verilog/ext_bus_pkg.sv
// Constants for the external memory bus strobe block
package ext_bus_pkg;

  // Oscillator clocks per machine cycle, standard and double speed
  localparam int unsigned CLKS_PER_MC_STD    = 12;
  localparam int unsigned CLKS_PER_MC_DS     = 6;
  // Machine cycles the reset pin must stay high
  localparam int unsigned RESET_HOLD_MC      = 2;
  localparam logic [4:0]  RESET_HOLD_CLK_STD = 5'(RESET_HOLD_MC * CLKS_PER_MC_STD);
  localparam logic [4:0]  RESET_HOLD_CLK_DS  = 5'(RESET_HOLD_MC * CLKS_PER_MC_DS);
  // Clocks the reset pin is driven high after a watchdog reset
  localparam logic [6:0]  WDT_DRIVE_CLKS     = 7'h60;

  // Reset values
  localparam logic        SELECT_LATCH_RESET = 1'b1;
  localparam logic        STROBE_N_IDLE      = 1'b1;

  // The six states of one machine cycle
  typedef enum logic [2:0] {
    ST_S1 = 3'b000,
    ST_S2 = 3'b001,
    ST_S3 = 3'b010,
    ST_S4 = 3'b011,
    ST_S5 = 3'b100,
    ST_S6 = 3'b101
  } mc_state_t;

endpackage // ext_bus_pkg

// File: test/ext_mem_model.sv
// External memory side model: strobe edge counters and shared pin wires
module ext_mem_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  strobes,
  input  wire logic        ale_pin_out,
  input  wire logic        ale_pin_oe,
  input  wire logic        pulse_drive,
  input  wire logic        rst_pin_out,
  input  wire logic        rst_pin_oe,
  input  wire logic        rst_press,
  output logic             ale_pin_in,
  output logic             rst_pin_in,
  output logic [3:0][7:0]  cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] prev;
  assign ale_pin_in = ale_pin_oe ? ale_pin_out : pulse_drive;
  assign rst_pin_in = rst_pin_oe ? rst_pin_out : rst_press;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt  <= '0;
      prev <= '0;
    end
    else
    begin
      prev <= strobes;
      for (int i = 0; i < 4; i++)
        if (strobes[i] && !prev[i])
          cnt[i] <= cnt[i] + 8'h01;
    end
  end
endmodule // ext_mem_model

// File: test/ext_bus_strobes_tb.sv
// Self-checking bench for the external bus strobe block
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module ext_bus_strobes_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, double_speed_mode, latch_strobe_disable_bit, security_level1;
  logic flash_programming, fetch_in_internal_range, xdata_access, xdata_write;
  logic watchdog_reset, external_fetch_select, rst_pin_in, rst_pin_out, rst_pin_oe;
  logic ale_pin_in, ale_pin_out, ale_pin_oe, program_pulse_input, program_store_strobe_n;
  logic xdata_read_strobe_n, xdata_write_strobe_n, system_reset, machine_cycle_start;
  logic            pulse_drive;
  logic            rst_press;
  logic [3:0][7:0] cnt;
  int              fail_count;
  int              compares;
  wire  [3:0]      strobes = {~xdata_write_strobe_n, ~xdata_read_strobe_n,
                              ~program_store_strobe_n, ale_pin_out};

  ext_bus_strobes u_dut (.clk, .reset_n, .double_speed_mode, .latch_strobe_disable_bit,
    .security_level1, .flash_programming, .fetch_in_internal_range, .xdata_access,
    .xdata_write, .watchdog_reset, .external_fetch_select, .rst_pin_in, .rst_pin_out,
    .rst_pin_oe, .ale_pin_in, .ale_pin_out, .ale_pin_oe, .program_pulse_input,
    .program_store_strobe_n, .xdata_read_strobe_n, .xdata_write_strobe_n,
    .system_reset, .machine_cycle_start);

  ext_mem_model u_mem (.clk, .reset_n, .strobes, .ale_pin_out, .ale_pin_oe, .pulse_drive,
    .rst_pin_out, .rst_pin_oe, .rst_press(rst_press), .ale_pin_in, .rst_pin_in, .cnt);

  task automatic wrap_up();
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Ends on the edge that samples the cycle inputs
  task automatic wait_mcs();
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(negedge clk);
      if (machine_cycle_start === 1'b1)
        break;
    end
    // A missing cycle start counts as a mismatch; the run still ends in the report
    if (i == 40)
      fail_count++;
    @(posedge clk);
  endtask

  // Counts strobe activations over whole machine cycles
  task automatic measure(input int n, input logic [7:0] a, p, r, w);
    logic [3:0][7:0] b;
    wait_mcs();
    xdata_access <= 1'b0;
    xdata_write  <= 1'b0;
    @(negedge clk);
    b = cnt;
    repeat (n * (double_speed_mode ? ext_bus_pkg::CLKS_PER_MC_DS
                                   : ext_bus_pkg::CLKS_PER_MC_STD)) @(negedge clk);
    `CHK(8'(cnt[0] - b[0]), a)
    `CHK(8'(cnt[1] - b[1]), p)
    `CHK(8'(cnt[2] - b[2]), r)
    `CHK(8'(cnt[3] - b[3]), w)
    // Callers change inputs on the rising edge
    @(posedge clk);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    #(40 * 20000);
    fail_count++;
    wrap_up();
  end

  initial
  begin
    {reset_n, double_speed_mode, latch_strobe_disable_bit, flash_programming} = '0;
    {fetch_in_internal_range, xdata_access, xdata_write, watchdog_reset} = '0;
    {pulse_drive, rst_press, fail_count, compares} = '0;
    security_level1 = 1'b1;
    // all code external while pin low
    external_fetch_select = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    measure(4, 8'h08, 8'h08, 8'h00, 8'h00);
    xdata_access <= 1'b1;
    xdata_write  <= 1'b1;
    measure(4, 8'h07, 8'h06, 8'h00, 8'h01);
    double_speed_mode <= 1'b1;
    wait_mcs();
    measure(4, 8'h08, 8'h08, 8'h00, 8'h00);
    xdata_access <= 1'b1;
    measure(4, 8'h07, 8'h06, 8'h01, 8'h00);
    external_fetch_select    <= 1'b1;
    fetch_in_internal_range  <= 1'b1;
    latch_strobe_disable_bit <= 1'b1;
    wait_mcs();
    measure(2, 8'h04, 8'h04, 8'h00, 8'h00);
    security_level1 <= 1'b0;
    wait_mcs();
    measure(2, 8'h00, 8'h00, 8'h00, 8'h00);
    latch_strobe_disable_bit <= 1'b0;
    wait_mcs();
    measure(2, 8'h04, 8'h00, 8'h00, 8'h00);
    latch_strobe_disable_bit <= 1'b1;
    xdata_access <= 1'b1;
    measure(2, 8'h01, 8'h00, 8'h01, 8'h00);
    // Short press is ignored, a long one resets
    rst_press <= 1'b1;
    repeat (10) @(negedge clk);
    `CHK(system_reset, 1'b0)
    repeat (10) @(negedge clk);
    `CHK(system_reset, 1'b1)
    @(posedge clk);
    rst_press <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK(system_reset, 1'b0)
    @(posedge clk);
    watchdog_reset <= 1'b1;
    @(posedge clk);
    watchdog_reset <= 1'b0;
    @(negedge clk);
    `CHK({rst_pin_oe, rst_pin_in, system_reset}, 3'h7)
    repeat (100) @(negedge clk);
    `CHK({rst_pin_oe, system_reset}, 2'h0)
    @(posedge clk);
    flash_programming <= 1'b1;
    pulse_drive       <= 1'b1;
    repeat (3) @(negedge clk);
    `CHK({ale_pin_oe, ale_pin_out, program_pulse_input}, 3'h1)
    wrap_up();
  end
endmodule // ext_bus_strobes_tb
